// File: hdl/pgd_regs.svh
// Register offsets, field positions, reset values and counts of the group.
`ifndef PGD_REGS_SVH
`define PGD_REGS_SVH
`define PGD_OFS_MIN_PIXEL    8'h0C
`define PGD_OFS_GRABBER      8'h0D
`define PGD_OFS_INV_REV      8'h40
`define PGD_OFS_OTP_CONFIG   8'h51
`define PGD_OFS_OTP_CTRL     8'h54
`define PGD_GRAB_VALID_BIT   7
`define PGD_OTP_EN_BIT       0
`define PGD_OTP_WR_BIT       0
`define PGD_OTP_RD_BIT       1
`define PGD_OTP_LOCK_BIT     3
`define PGD_RST_BYTE         8'h00
`define PGD_COLUMN_LEN       19
`define PGD_PIXEL_COUNT      361
`endif

// File: hdl/pgd_pkg.sv
// Types shared by the pixel grabber register group.
package pgd_pkg;
    typedef logic [7:0] pgd_byte_t;
    typedef logic [8:0] pgd_index_t;
    typedef enum logic [1:0] {
        PGD_IDLE  = 2'b00,
        PGD_ARMED = 2'b01,
        PGD_HELD  = 2'b10
    } pgd_grab_state_t;
endpackage : pgd_pkg

// File: hdl/pgd_grabber.sv
// Pixel grabber: one-per-frame capture with index stepping.
`timescale 1ns/1ps
`include "pgd_regs.svh"
module pgd_grabber (
    input  wire logic                i_mclk,
    input  wire logic                i_rst_b,
    input  wire logic                i_frame_start,
    input  wire logic                i_pix_valid,
    input  wire pgd_pkg::pgd_index_t i_pix_index,
    input  wire logic [6:0]          i_pix_data,
    input  wire logic                i_rearm,
    input  wire logic                i_advance,
    output logic                     o_held,
    output logic [6:0]               o_pixel,
    output pgd_pkg::pgd_index_t      o_index
);
    import pgd_pkg::*;
    pgd_grab_state_t state_q;
    logic            in_frame_q;
    logic [6:0]      pixel_q;
    pgd_index_t      index_q;
    logic            capture;

    assign capture = (state_q == PGD_ARMED) && in_frame_q && i_pix_valid
                     && (i_pix_index == index_q);

    // A rearm waits for the next frame start so pixel 0 comes from a new image.
    // Capturing drops the frame mark, so a read in mid-frame waits for the next.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            in_frame_q <= 1'b0;
        end else if (i_rearm) begin
            in_frame_q <= 1'b0;
        end else if (capture) begin
            in_frame_q <= 1'b0;
        end else if (i_frame_start) begin
            in_frame_q <= (state_q == PGD_ARMED);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_q <= PGD_IDLE;
            index_q <= '0;
            pixel_q <= '0;
        end else if (i_rearm) begin
            state_q <= PGD_ARMED;
            index_q <= '0;
        end else begin
            case (state_q)
                PGD_ARMED: begin
                    if (capture) begin
                        pixel_q <= i_pix_data;
                        state_q <= PGD_HELD;
                    end
                end
                PGD_HELD: begin
                    if (i_advance) begin
                        state_q <= PGD_ARMED;
                        if (index_q == 9'(`PGD_PIXEL_COUNT - 1)) begin
                            index_q <= '0;
                        end else begin
                            index_q <= index_q + 9'h001;
                        end
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    assign o_held  = (state_q == PGD_HELD);
    assign o_pixel = pixel_q;
    assign o_index = index_q;

    // The capture needs a frame start between arming and a held pixel.
    sequence s_capture;
        capture;
    endsequence
    property p_one_per_frame;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_capture |=> !in_frame_q;
    endproperty
    a_one_per_frame: assert property (p_one_per_frame)
        else $error("Grabber captured without a new frame.");

    property p_index_range;
        @(posedge i_mclk) disable iff (!i_rst_b)
        index_q < 9'(`PGD_PIXEL_COUNT);
    endproperty
    a_index_range: assert property (p_index_range)
        else $error("Pixel index left range 0 to 360.");

    property p_rearm_zero;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_rearm |=> (index_q == 9'h000 && state_q == PGD_ARMED);
    endproperty
    a_rearm_zero: assert property (p_rearm_zero)
        else $error("Write did not arm grabber at pixel zero.");
endmodule : pgd_grabber

// File: hdl/pgd_top.sv
// Diagnostic register group: minimum pixel, grabber, revision, OTP enable.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "pgd_regs.svh"
module pgd_top #(
    parameter logic [7:0] REVISION_ID = 8'h5A  // Arbitrary value.
) (
    input  wire logic                i_mclk,
    input  wire logic                i_rst_b,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output pgd_pkg::pgd_byte_t       o_rdata,
    input  wire logic                i_frame_start,
    input  wire logic                i_frame_end,
    input  wire logic                i_pix_valid,
    input  wire pgd_pkg::pgd_index_t i_pix_index,
    input  wire logic [6:0]          i_pix_data,
    input  wire logic [7:0]          i_otp_ctrl_cmd,
    output logic                     o_otp_wr_cmd,
    output logic                     o_otp_rd_cmd,
    output logic                     o_otp_lock_cmd
);
    import pgd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [6:0] min_run_q;
    logic [6:0] min_pixel_bits_q;
    logic       otp_en_q;
    logic       held;
    logic [6:0] grabbed_pixel_bits;
    pgd_index_t grab_index;
    logic       grab_wr;
    logic       grab_rd;
    logic       grab_adv;

    assign grab_wr  = i_wr && i_addr == `PGD_OFS_GRABBER;
    assign grab_rd  = i_rd && i_addr == `PGD_OFS_GRABBER;
    assign grab_adv = grab_rd && held;

    // Running minimum of the frame in progress, published at frame end.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            min_run_q        <= 7'h7F;
            min_pixel_bits_q <= 7'h00;
        end else if (i_frame_start) begin
            min_run_q <= 7'h7F;
        end else if (i_frame_end) begin
            min_pixel_bits_q <= min_run_q;
        end else if (i_pix_valid && i_pix_data < min_run_q) begin
            min_run_q <= i_pix_data;
        end
    end

    pgd_grabber u_grabber (
        .i_mclk        (i_mclk),
        .i_rst_b       (i_rst_b),
        .i_frame_start (i_frame_start),
        .i_pix_valid   (i_pix_valid),
        .i_pix_index   (i_pix_index),
        .i_pix_data    (i_pix_data),
        .i_rearm       (grab_wr),
        .i_advance     (grab_adv),
        .o_held        (held),
        .o_pixel       (grabbed_pixel_bits),
        .o_index       (grab_index)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            otp_en_q <= 1'b0;
        end else if (i_wr && i_addr == `PGD_OFS_OTP_CONFIG) begin
            otp_en_q <= i_wdata[`PGD_OTP_EN_BIT];
        end
    end

    // Commands follow the i_otp_ctrl_cmd bits one cycle later; a disabled enable drops them entirely.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_otp_wr_cmd   <= 1'b0;
            o_otp_rd_cmd   <= 1'b0;
            o_otp_lock_cmd <= 1'b0;
        end else begin
            o_otp_wr_cmd   <= otp_en_q && i_otp_ctrl_cmd[`PGD_OTP_WR_BIT];
            o_otp_rd_cmd   <= otp_en_q && i_otp_ctrl_cmd[`PGD_OTP_RD_BIT];
            o_otp_lock_cmd <= otp_en_q && i_otp_ctrl_cmd[`PGD_OTP_LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_rdata <= `PGD_RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `PGD_OFS_MIN_PIXEL:  o_rdata <= {1'b0, min_pixel_bits_q};
                `PGD_OFS_GRABBER:    o_rdata <= held ? {1'b1, grabbed_pixel_bits}
                                                     : `PGD_RST_BYTE;
                `PGD_OFS_INV_REV:    o_rdata <= ~REVISION_ID;
                `PGD_OFS_OTP_CONFIG: o_rdata <= {7'h00, otp_en_q};
                default:             o_rdata <= `PGD_RST_BYTE;
            endcase
        end else begin
            o_rdata <= `PGD_RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_min_top_zero;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $past(i_rd) && $past(i_addr) == `PGD_OFS_MIN_PIXEL |-> !o_rdata[7];
    endproperty
    a_min_top_zero: assert property (p_min_top_zero)
        else $error("Minimum pixel read with top bit set.");

    sequence s_valid_grab;
        grab_rd && held;
    endsequence
    property p_grab_valid;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_valid_grab |=> o_rdata[`PGD_GRAB_VALID_BIT] && !held;
    endproperty
    a_grab_valid: assert property (p_grab_valid)
        else $error("Valid grab did not report or re-arm.");

    property p_grab_empty;
        @(posedge i_mclk) disable iff (!i_rst_b)
        grab_rd && !held && !grab_wr |=>
            !o_rdata[7] && grab_index == $past(grab_index);
    endproperty
    a_grab_empty: assert property (p_grab_empty)
        else $error("Empty grab changed state or showed valid.");

    property p_inv_rev;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_rd && i_addr == `PGD_OFS_INV_REV |=> o_rdata == ~REVISION_ID;
    endproperty
    a_inv_rev: assert property (p_inv_rev)
        else $error("Inverse revision mismatch.");

    property p_otp_gate;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !otp_en_q |=> !o_otp_wr_cmd && !o_otp_rd_cmd && !o_otp_lock_cmd;
    endproperty
    a_otp_gate: assert property (p_otp_gate)
        else $error("OTP command passed while disabled.");

    property p_otp_cfg;
        @(posedge i_mclk) disable iff (!i_rst_b)
        i_rd && i_addr == `PGD_OFS_OTP_CONFIG |=>
            o_rdata == {7'h00, $past(otp_en_q)};
    endproperty
    a_otp_cfg: assert property (p_otp_cfg)
        else $error("OTP config reserved bits not zero.");

    property p_grab_hold;
        @(posedge i_mclk) disable iff (!i_rst_b)
        held && !grab_adv && !grab_wr |=>
            held && $stable(grabbed_pixel_bits);
    endproperty
    a_grab_hold: assert property (p_grab_hold)
        else $error("Held pixel lost before it was read.");

    property p_otp_pass;
        @(posedge i_mclk) disable iff (!i_rst_b)
        otp_en_q && i_otp_ctrl_cmd[`PGD_OTP_LOCK_BIT] |=> o_otp_lock_cmd;
    endproperty
    a_otp_pass: assert property (p_otp_pass)
        else $error("Enabled OTP lock command was dropped.");
endmodule : pgd_top

// File: verification/tb_top.sv
// Self-checking bench for the pixel grabber register group.
`timescale 1ns/1ps
`include "pgd_regs.svh"
module tb_top;
    import pgd_pkg::*;
    localparam logic [7:0] REV = 8'hA3;  // Arbitrary value.
    logic       i_mclk         = 1'b0;
    logic       i_rst_b        = 1'b0;
    logic [7:0] i_addr         = 8'h00;
    logic [7:0] i_wdata        = 8'h00;
    logic       i_wr           = 1'b0;
    logic       i_rd           = 1'b0;
    logic       i_frame_start  = 1'b0;
    logic       i_frame_end    = 1'b0;
    logic       i_pix_valid    = 1'b0;
    pgd_index_t i_pix_index    = 9'h000;
    logic [6:0] i_pix_data     = 7'h00;
    logic [7:0] i_otp_ctrl_cmd = 8'h00;
    pgd_byte_t  o_rdata;
    logic       o_otp_wr_cmd;
    logic       o_otp_rd_cmd;
    logic       o_otp_lock_cmd;
    logic [7:0] otp_cmds;
    int         n_errors = 0;
    int         checks   = 0;
    int         cycles   = 0;
    int         k;
    // Reset-value rows: address beside the byte it must read back.
    logic [7:0] row_addr [5] = '{8'h0C, 8'h0D, 8'h40, 8'h51, 8'h77};
    logic [7:0] row_exp  [5] = '{8'h00, 8'h00, ~REV, 8'h00, 8'h00};

    pgd_top #(.REVISION_ID(REV)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_frame_start(i_frame_start),
        .i_frame_end(i_frame_end), .i_pix_valid(i_pix_valid),
        .i_pix_index(i_pix_index), .i_pix_data(i_pix_data),
        .i_otp_ctrl_cmd(i_otp_ctrl_cmd), .o_otp_wr_cmd(o_otp_wr_cmd),
        .o_otp_rd_cmd(o_otp_rd_cmd), .o_otp_lock_cmd(o_otp_lock_cmd));

    assign otp_cmds = {5'h00, o_otp_wr_cmd, o_otp_rd_cmd, o_otp_lock_cmd};

    always #4 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd

    task automatic pix(input pgd_index_t idx, input logic [6:0] d);
        @(posedge i_mclk);
        i_pix_valid <= 1'b1;
        i_pix_index <= idx;
        i_pix_data  <= d;
        @(posedge i_mclk);
        i_pix_valid <= 1'b0;
    endtask : pix

    // Pixels first to first plus 3 carry base minus offset.
    // The minimum of such a frame is therefore base minus 3 for a base of 3 or more.
    task automatic send_frame(input pgd_index_t first,
                              input logic [6:0] base);
        int i;
        @(posedge i_mclk);
        i_frame_start <= 1'b1;
        @(posedge i_mclk);
        i_frame_start <= 1'b0;
        for (i = 0; i < 4; i++) begin
            i_pix_valid <= 1'b1;
            i_pix_index <= first + pgd_index_t'(i);
            i_pix_data  <= base - 7'(i);
            @(posedge i_mclk);
        end
        i_pix_valid <= 1'b0;
        i_frame_end <= 1'b1;
        @(posedge i_mclk);
        i_frame_end <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask : send_frame
    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(row_addr[k], row_exp[k]);
        end
        $display("test reset values done");
        // A write to the read-only minimum must not stick.
        wr(`PGD_OFS_MIN_PIXEL, 8'h55);
        rd(`PGD_OFS_MIN_PIXEL, 8'h00);
        @(posedge i_mclk);
        i_otp_ctrl_cmd <= 8'h0B;
        repeat (3) @(posedge i_mclk);
        #1 chk(otp_cmds, 8'h00);
        wr(`PGD_OFS_OTP_CONFIG, 8'hFF);
        rd(`PGD_OFS_OTP_CONFIG, 8'h01);
        chk(otp_cmds, 8'h07);
        wr(`PGD_OFS_OTP_CONFIG, 8'h00);
        repeat (3) @(posedge i_mclk);
        #1 chk(otp_cmds, 8'h00);
        @(posedge i_mclk);
        i_otp_ctrl_cmd <= 8'h00;
        $display("test otp enable done");
        wr(`PGD_OFS_GRABBER, 8'h00);
        send_frame(9'h000, 7'h40);
        rd(`PGD_OFS_MIN_PIXEL, 8'h3D);
        rd(`PGD_OFS_GRABBER, 8'hC0);
        rd(`PGD_OFS_GRABBER, 8'h00);
        send_frame(9'h000, 7'h50);
        rd(`PGD_OFS_GRABBER, 8'hCF);
        send_frame(9'h000, 7'h60);
        rd(`PGD_OFS_GRABBER, 8'hDE);
        // Any value written restarts the upload at pixel zero.
        wr(`PGD_OFS_GRABBER, 8'hA5);
        send_frame(9'h000, 7'h20);
        rd(`PGD_OFS_GRABBER, 8'hA0);
        rd(`PGD_OFS_MIN_PIXEL, 8'h1D);
        $display("test grabber done");
        // A read in mid-frame must not let a second pixel of that frame in.
        wr(`PGD_OFS_GRABBER, 8'h00);
        @(posedge i_mclk);
        i_frame_start <= 1'b1;
        @(posedge i_mclk);
        i_frame_start <= 1'b0;
        pix(9'h000, 7'h33);
        rd(`PGD_OFS_GRABBER, 8'hB3);
        pix(9'h001, 7'h34);
        rd(`PGD_OFS_GRABBER, 8'h00);
        $display("test one pixel per frame done");
        // Full upload: one valid read per pixel, polling in between.
        wr(`PGD_OFS_GRABBER, 8'h00);
        for (k = 0; k < `PGD_PIXEL_COUNT; k++) begin
            rd(`PGD_OFS_GRABBER, 8'h00);
            send_frame(pgd_index_t'(k), 7'(k));
            rd(`PGD_OFS_GRABBER, {1'b1, 7'(k)});
        end
        // After pixel 360 the index wraps to pixel zero.
        send_frame(9'h000, 7'h11);
        rd(`PGD_OFS_GRABBER, 8'h91);
        $display("test full upload done");
        report_and_stop();
    end
endmodule : tb_top
